// file: rtl/bus_xcvr_pkg.sv
// shared constants and types for the registered bus transceiver
package bus_xcvr_pkg;

  // ==========================================================
  // widths
  localparam int SLICE_COUNT = 3;
  localparam int LOAD_SEL_W = 2;
  localparam int DRIVE_EN_W = 2;

  // ==========================================================
  // load select field positions and reset values
  localparam int LOAD_A_BIT = 0;
  localparam int LOAD_B_BIT = 1;
  localparam logic [SLICE_COUNT-1:0] SLICE_RST = 3'h0;
  localparam logic DRIVE_EN_RST = 1'h0;
  localparam logic CLK_SAMPLE_RST = 1'h0;

  // ==========================================================
  // parallel transmit data groups
  typedef struct packed {
    logic [SLICE_COUNT-1:0] group_b;
    logic [SLICE_COUNT-1:0] group_a;
  } tx_groups_t;

  // ==========================================================
  // shared line pin, two signals per slice
  typedef struct packed {
    logic [SLICE_COUNT-1:0] out;
    logic [SLICE_COUNT-1:0] oe;
  } line_drive_t;

endpackage

// file: rtl/registered_bus_transceiver.sv
// three slice registered bus transceiver with cutoff shared line outputs
`timescale 1ns/1ps

module registered_bus_transceiver
  import bus_xcvr_pkg::*;
#(
  parameter int SLICES = SLICE_COUNT
) (
  input wire logic ref_clk,
  input wire logic sys_rst,
  input wire logic first_clock,
  input wire logic second_clock,
  input wire logic [LOAD_SEL_W-1:0] transmit_load_select,
  input wire logic [DRIVE_EN_W-1:0] bus_drive_enable,
  input wire logic receive_capture_gate,
  input wire tx_groups_t tx_groups,
  input wire logic [SLICES-1:0] shared_line_in,
  output logic [SLICES-1:0] shared_line_outputs,
  output logic [SLICES-1:0] shared_line_oe,
  output logic [SLICES-1:0] receive_outputs
);

  // ==========================================================
  // clock pin samples
  // both clock pins are sampled as ordinary inputs; an event is a
  // rising sample on either, so simultaneous edges give one update
  logic first_clock_q;
  logic second_clock_q;
  wire logic first_clock_d;
  wire logic second_clock_d;

  assign first_clock_d = first_clock;
  assign second_clock_d = second_clock;

  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      first_clock_q <= CLK_SAMPLE_RST;
    end else begin
      first_clock_q <= first_clock_d;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      second_clock_q <= CLK_SAMPLE_RST;
    end else begin
      second_clock_q <= second_clock_d;
    end
  end

  // ==========================================================
  // clock event detection
  // a pin held high gives no further events until it drops again
  wire logic first_rise;
  wire logic second_rise;
  wire logic clock_event;

  assign first_rise = first_clock & ~first_clock_q;
  assign second_rise = second_clock & ~second_clock_q;
  assign clock_event = first_rise | second_rise;

  // ==========================================================
  // drive enable decode
  // either enable pin keeps the line drivable; only both low cut off
  wire logic any_drive_en;
  wire logic drive_en_d;
  logic drive_en_q;

  assign any_drive_en = |bus_drive_enable;
  assign drive_en_d = clock_event ? any_drive_en : drive_en_q;

  // ==========================================================
  // registered drive enable, common to all slices
  // on an event the pin enable feeds the line flops directly, at the same edge that loads drive_en_q
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      drive_en_q <= DRIVE_EN_RST;
    end else begin
      drive_en_q <= drive_en_d;
    end
  end

  // ==========================================================
  // load select decode
  // group a wins if both selects are high
  wire logic load_a;
  wire logic load_b;
  wire logic load_any;
  wire logic tx_load;
  wire logic rx_load;

  assign load_a = transmit_load_select[LOAD_A_BIT];
  assign load_b = transmit_load_select[LOAD_B_BIT] & ~load_a;
  assign load_any = load_a | load_b;
  assign tx_load = clock_event & load_any;
  assign rx_load = clock_event & receive_capture_gate;

  // ==========================================================
  // slice storage
  logic [SLICES-1:0] tx_q;
  logic [SLICES-1:0] rx_q;
  logic [SLICES-1:0] line_out_q;
  logic [SLICES-1:0] line_oe_q;

  // ==========================================================
  // slice next values
  // line and enable share one next value so line and enable move together
  wire logic [SLICES-1:0] new_bits;
  wire logic [SLICES-1:0] tx_d;
  wire logic [SLICES-1:0] rx_d;
  wire logic [SLICES-1:0] drive_d;
  wire logic [SLICES-1:0] line_out_d;
  wire logic [SLICES-1:0] line_oe_d;

  // ==========================================================
  // bit slices
  genvar i;
  generate
    for (i = 0; i < SLICES; i++) begin : g_slice
      // transmit source select
      assign new_bits[i] = load_a ? tx_groups.group_a[i] :
                           tx_groups.group_b[i];

      // hold unless a load is selected on this event
      assign tx_d[i] = tx_load ? new_bits[i] : tx_q[i];

      // receive path samples the resolved line level
      assign rx_d[i] = rx_load ? shared_line_in[i] : rx_q[i];

      // low or disabled releases the line instead of driving low
      assign drive_d[i] = tx_d[i] & drive_en_d;

      assign line_out_d[i] = drive_d[i];
      assign line_oe_d[i] = drive_d[i];

      always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
          tx_q[i] <= SLICE_RST[i];
        end else begin
          tx_q[i] <= tx_d[i];
        end
      end

      always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
          rx_q[i] <= SLICE_RST[i];
        end else begin
          rx_q[i] <= rx_d[i];
        end
      end

      always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
          line_out_q[i] <= SLICE_RST[i];
        end else begin
          line_out_q[i] <= line_out_d[i];
        end
      end

      always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
          line_oe_q[i] <= SLICE_RST[i];
        end else begin
          line_oe_q[i] <= line_oe_d[i];
        end
      end
    end
  endgenerate

  // ==========================================================
  // outputs straight from flip-flops
  // no gating here, so every output pin sees a flop directly
  generate
    for (i = 0; i < SLICES; i++) begin : g_out
      assign shared_line_outputs[i] = line_out_q[i];
      assign shared_line_oe[i] = line_oe_q[i];
      assign receive_outputs[i] = rx_q[i];
    end
  endgenerate

endmodule

// file: tb/line_partner.sv
// far-side driver on the shared lines, pulled low when released
`timescale 1ns/1ps
module line_partner (
  input logic ref_clk,
  input logic [2:0] shared_line_oe,
  output logic [2:0] p_oe = 3'h0,
  output wire [2:0] shared_line_in
);
  always @(negedge ref_clk) p_oe <= 3'($random);
  assign shared_line_in = shared_line_oe | p_oe;
endmodule

// file: tb/xcvr_chk.sv
// port assertions for the transceiver
`timescale 1ns/1ps
module xcvr_chk (
  input logic ref_clk, sys_rst, first_clock, second_clock,
  input logic receive_capture_gate, input logic [1:0] bus_drive_enable,
  input logic [1:0] transmit_load_select, input logic [5:0] tx_groups,
  input logic [2:0] shared_line_in, receive_outputs,
  input logic [2:0] shared_line_outputs, shared_line_oe);
  logic [1:0] p_q;
  wire [1:0] p = {first_clock, second_clock};
  wire ev = |(p & ~p_q), on = |bus_drive_enable, g = receive_capture_gate;
  wire [2:0] rx = receive_outputs, oe = shared_line_oe, li = shared_line_in;
  always_ff @(posedge ref_clk) p_q <= sys_rst ? 2'h0 : p;
  default clocking @(posedge ref_clk); endclocking
  default disable iff (sys_rst);
  a_cut_off: assert property (ev & !on |=> !oe)
    else $error("cutoff");
  a_rx_hold: assert property (ev & !g |=> $stable(rx))
    else $error("rx hold");
  a_rx_load: assert property (ev & g |=> rx == $past(li))
    else $error("rx load");
  a_no_event: assert property (!ev |=> $stable({rx, oe}))
    else $error("quiet");
  a_oe_match: assert property (oe == shared_line_outputs)
    else $error("oe");
  a_tx_load: assert property (ev & on & (transmit_load_select == 2'h1)
    |=> shared_line_outputs == $past(tx_groups[2:0]))
    else $error("tx load");
endmodule
bind registered_bus_transceiver xcvr_chk u_xcvr_chk (.*);

// file: tb/test_registered_bus_transceiver.sv
// random bench with a reference model of the transceiver
`timescale 1ns/1ps
module test_registered_bus_transceiver;
  logic ref_clk = 0, sys_rst = 1, first_clock = 0, second_clock = 0;
  logic receive_capture_gate = 0, en = 0;
  logic [1:0] transmit_load_select = 2'h0, bus_drive_enable = 2'h0;
  logic [1:0] p_q = 2'h0;
  logic [2:0] tx = 3'h0, rx = 3'h0;
  bus_xcvr_pkg::tx_groups_t tx_groups = 6'h0;
  wire [2:0] shared_line_in, shared_line_outputs, shared_line_oe;
  wire [2:0] receive_outputs, p_oe, drv = tx & {3{en}};
  int seed = 48, bad_count = 0, compares = 0;
  always #4 ref_clk = ~ref_clk;
  registered_bus_transceiver u_registered_bus_transceiver (.*);
  line_partner u_line_partner (.*);
  task automatic chk(string n, logic [2:0] e, logic [2:0] g);
    compares++;
    bad_count += (g !== e);
    if (g !== e) $display("Error %s expected %h seen %h", n, e, g);
  endtask
  task automatic close_out;
    if (bad_count == 0 && compares > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  initial begin
    repeat (2) @(negedge ref_clk);
    sys_rst = 0;
    repeat (3000) begin
      @(negedge ref_clk);
      chk("line", drv, shared_line_outputs);
      chk("oe", drv, shared_line_oe);
      chk("rx", rx, receive_outputs);
      {first_clock, second_clock, receive_capture_gate, tx_groups,
        transmit_load_select, bus_drive_enable} = 13'($random(seed));
      // both pins rise together, group a must win over b
      if (compares < 90) {first_clock, second_clock, transmit_load_select} =
        {compares[3], compares[3], 2'h3};
      @(posedge ref_clk);
      if (|({first_clock, second_clock} & ~p_q)) begin
        if (receive_capture_gate) rx = drv | p_oe;
        if (transmit_load_select[0]) tx = tx_groups.group_a;
        else if (transmit_load_select[1]) tx = tx_groups.group_b;
        en = |bus_drive_enable;
      end
      p_q = {first_clock, second_clock};
    end
    close_out();
  end
endmodule
